// [core/snl_map.svh]
`ifndef SNL_MAP_SVH
`define SNL_MAP_SVH

// opcodes
`define SNL_OP_WREN     8'h06
`define SNL_OP_SEC_PROG 8'h42
`define SNL_OP_SEC_READ 8'h48
`define SNL_OP_LOCK     8'h36
`define SNL_OP_UNLOCK   8'h39
`define SNL_OP_RD_LOCK  8'h3D
`define SNL_OP_GLOCK    8'h7E
`define SNL_OP_GUNLOCK  8'h98
`define SNL_OP_RST_EN   8'h66
`define SNL_OP_RST      8'h99

// security register address fields
`define SNL_SEC_FIRST   4'h1
`define SNL_SEC_LAST    4'h3
`define SNL_SEC_BYTES   256
`define SNL_SEC_COUNT   3
`define SNL_ERASED      8'hFF

// lock array layout: 16 sectors, 254 blocks, 16 sectors
`define SNL_LOCK_COUNT  286
`define SNL_TOP_BLOCK   8'hFF
`define SNL_MID_BASE    9'h00F
`define SNL_TOP_BASE    9'h10E

// timing
`define SNL_CLK_MHZ     200
`define SNL_TRST_US     30
`define SNL_PROG_CYC    64

`endif

// [core/snl_pkg.sv]
package snl_pkg;

    // gray-coded frame phases
    typedef enum logic [2:0] {
        SNL_ST_OP    = 3'h0,
        SNL_ST_ADDR  = 3'h1,
        SNL_ST_DUMMY = 3'h3,
        SNL_ST_DATA  = 3'h2,
        SNL_ST_IGN   = 3'h6
    } snl_state_t;

    // qualified link events after the pin synchronisers
    typedef struct packed {
        logic sck_rise;
        logic sck_fall;
        logic cs_rise;
        logic cs_high;
        logic din;
    } snl_pin_t;

endpackage : snl_pkg

// [core/snl_core.sv]
`timescale 1ns/1ps
`include "snl_map.svh"
// Function
// - opcode 42h, 24-bit address, 1..256 bytes; only erased bytes get written.
// - security program accepted only with write_enable_latch set.
// - address bits 23..16 and 11..8 zero; 15..12 pick register 1..3.
// - program to an otp-locked security register is ignored.
// - opcode 48h, 24-bit address, eight dummy clocks, then data.
// - bits sampled on clock rise; read data driven on fall, msb first.
// - read address increments per byte, wraps FFh to 00h in register.
// - lock bits protect only when protect_scheme_select is 1, else range bits.
// - lock bits are volatile and set to 1 at power-up and soft reset.
// - 36h plus address, then chip select high, locks one block; needs latch.
// - 39h plus address, then chip select high, unlocks one block; needs latch.
// - 3Dh plus address shifts out lock status, lsb 1 means locked.
// - 7Eh then chip select high sets all lock bits; needs latch.
// - 98h then chip select high clears all lock bits; needs latch.
// - reset needs 66h then 99h; any other command cancels the enable.
// - accepted reset aborts work, clears latch and volatile settings.
// - reset takes 30us, all commands rejected meanwhile.
module snl_core
    import snl_pkg::*;
#(
    parameter int TRST_CYC = `SNL_TRST_US * `SNL_CLK_MHZ,
    parameter int PROG_CYC = `SNL_PROG_CYC,
    parameter int N_LOCKS  = `SNL_LOCK_COUNT
)(
    input  wire logic         i_clk,            // 200 MHz system clock
    input  wire logic         i_resetn,         // power-on reset, sync, active low
    input  wire logic         i_cs_n,           // chip select pin, active low
    input  wire logic         i_sclk,           // serial clock pin
    input  wire logic         i_serial_in,      // serial data pin
    input  wire logic [2:0]   i_otp_lock_bits,  // per security register otp lock
    input  wire logic         i_protect_scheme_select, // 1: lock bits govern
    input  wire logic         i_range_prot,     // verdict of range protection
    input  wire logic [23:0]  i_query_addr,     // array address under check
    output logic              o_serial_out,     // serial data out
    output logic              o_so_oe_n,        // low while driving serial out
    output logic              o_busy,           // internal program running
    output logic              o_wel,            // write_enable_latch
    output logic              o_reset_busy,     // soft reset in progress
    output logic              o_soft_reset,     // pulse: clear suspend/read/wrap
    output logic              o_protected       // query address is protected
);
    localparam int SEC_DEPTH = `SNL_SEC_COUNT * `SNL_SEC_BYTES;

    logic [2:0]  cs_s_r, ck_s_r, di_s_r;
    logic        cs_st_r, ck_st_r;
    snl_pin_t    pin;
    snl_state_t  state_r, state_nxt;
    logic [2:0]  bit_r;
    logic [6:0]  sh_r;
    logic [7:0]  op_r, tx_r;
    logic [23:0] addr_r;
    logic [1:0]  abyte_r;
    logic        ready_r, prog_ok_r, wrote_r;
    logic        wel_r, busy_r, rst_en_r, so_r, oe_n_r, srst_r, prot_r;
    logic [15:0] pcnt_r;
    logic [15:0] rcnt_r;
    logic        rbusy_r;
    logic [N_LOCKS-1:0] lock_r;
    logic [7:0]  mem_r [0:SEC_DEPTH-1];

    // three-stage synchronisers; a level counts once stages two and three agree
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            cs_s_r  <= 3'h7;
            ck_s_r  <= 3'h0;
            di_s_r  <= 3'h0;
            cs_st_r <= 1'b1;
            ck_st_r <= 1'b0;
        end
        else
        begin
            cs_s_r <= {cs_s_r[1:0], i_cs_n};
            ck_s_r <= {ck_s_r[1:0], i_sclk};
            di_s_r <= {di_s_r[1:0], i_serial_in};
            if (cs_s_r[1] == cs_s_r[2])
                cs_st_r <= cs_s_r[2];
            if (ck_s_r[1] == ck_s_r[2])
                ck_st_r <= ck_s_r[2];
        end
    end

    assign pin.sck_rise = ck_s_r[1] & ck_s_r[2] & ~ck_st_r & ~cs_st_r;
    assign pin.sck_fall = ~ck_s_r[1] & ~ck_s_r[2] & ck_st_r & ~cs_st_r;
    assign pin.cs_rise  = cs_s_r[1] & cs_s_r[2] & ~cs_st_r;
    assign pin.cs_high  = cs_st_r;
    assign pin.din      = di_s_r[2];

    function automatic logic [8:0] lock_index(input logic [23:0] a);
        logic [8:0] idx;
        idx = `SNL_MID_BASE + {1'b0, a[23:16]};
        if (a[23:16] == 8'h00)
            idx = {5'h00, a[15:12]};
        else if (a[23:16] == `SNL_TOP_BLOCK)
            idx = `SNL_TOP_BASE + {5'h00, a[15:12]};
        return idx;
    endfunction : lock_index

    function automatic logic sec_valid(input logic [23:0] a);
        return (a[23:16] == 8'h00) && (a[11:8] == 4'h0) &&
               (a[15:12] >= `SNL_SEC_FIRST) && (a[15:12] <= `SNL_SEC_LAST);
    endfunction : sec_valid

    function automatic logic [9:0] sec_index(input logic [23:0] a);
        return {2'(a[13:12] - 2'h1), a[7:0]};
    endfunction : sec_index

    wire        rst_busy  = (rcnt_r != 16'h0000);
    wire        byte_done = pin.sck_rise & (bit_r == 3'h7);
    wire [7:0]  byte_w    = {sh_r, pin.din};
    wire        op_done   = byte_done & (state_r == SNL_ST_OP);
    wire        addr_done = byte_done & (state_r == SNL_ST_ADDR) & (abyte_r == 2'h2);
    wire [23:0] addr_full = {addr_r[15:0], byte_w};
    wire [23:0] addr_inc  = {addr_r[23:8], 8'(addr_r[7:0] + 8'h01)};
    wire [23:0] look_addr = (state_r == SNL_ST_ADDR) ? addr_full :
                            (state_r == SNL_ST_DATA) ? addr_inc : addr_r;
    wire        is_read   = (op_r == `SNL_OP_SEC_READ) || (op_r == `SNL_OP_RD_LOCK);
    wire [7:0]  tx_nxt    = (op_r == `SNL_OP_RD_LOCK) ?
                            {7'h00, lock_r[lock_index(look_addr)]} :
                            sec_valid(look_addr) ? mem_r[sec_index(look_addr)] :
                            `SNL_ERASED;
    wire [9:0]  wr_idx    = sec_index(addr_r);
    wire        mem_we    = byte_done & (state_r == SNL_ST_DATA) &
                            (op_r == `SNL_OP_SEC_PROG) & prog_ok_r &
                            (mem_r[wr_idx] == `SNL_ERASED);
    wire        sel_otp   = i_otp_lock_bits[2'(addr_full[13:12] - 2'h1)];
    wire        sw_rst    = op_done & ~rst_busy & rst_en_r & (byte_w == `SNL_OP_RST);
    // single-shot commands act only when chip select rises on a byte boundary
    wire        apply     = pin.cs_rise & ready_r & (bit_r == 3'h0) & wel_r &
                            ~rst_busy & ~busy_r;
    wire        lock_one  = apply & (op_r == `SNL_OP_LOCK);
    wire        unlock_one = apply & (op_r == `SNL_OP_UNLOCK);
    wire        glob_set  = apply & (op_r == `SNL_OP_GLOCK);
    wire        glob_clr  = apply & (op_r == `SNL_OP_GUNLOCK);
    wire [8:0]  tgt_idx   = lock_index(addr_r);

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            SNL_ST_OP:
            begin
                state_nxt = SNL_ST_IGN;
                if (!rst_busy && !busy_r &&
                    (byte_w == `SNL_OP_SEC_PROG || byte_w == `SNL_OP_SEC_READ ||
                     byte_w == `SNL_OP_LOCK || byte_w == `SNL_OP_UNLOCK ||
                     byte_w == `SNL_OP_RD_LOCK))
                    state_nxt = SNL_ST_ADDR;
            end
            SNL_ST_ADDR:
            begin
                if (abyte_r == 2'h2)
                    state_nxt = (op_r == `SNL_OP_SEC_READ) ? SNL_ST_DUMMY :
                                (op_r == `SNL_OP_LOCK || op_r == `SNL_OP_UNLOCK) ?
                                SNL_ST_IGN : SNL_ST_DATA;
            end
            SNL_ST_DUMMY: state_nxt = SNL_ST_DATA;
            SNL_ST_DATA:  state_nxt = SNL_ST_DATA;
            SNL_ST_IGN:   state_nxt = SNL_ST_IGN;
            default:      state_nxt = SNL_ST_IGN;
        endcase
    end

    // frame sequencing; everything restarts while chip select is high
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || pin.cs_high)
        begin
            state_r <= SNL_ST_OP;
            bit_r   <= 3'h0;
            abyte_r <= 2'h0;
        end
        else if (pin.sck_rise)
        begin
            bit_r <= 3'(bit_r + 3'h1);
            if (byte_done)
                state_r <= state_nxt;
            if (byte_done && state_r == SNL_ST_ADDR)
                abyte_r <= 2'(abyte_r + 2'h1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            sh_r   <= 7'h00;
            op_r   <= 8'h00;
            addr_r <= 24'h000000;
            tx_r   <= 8'h00;
        end
        else if (pin.sck_rise)
        begin
            sh_r <= byte_w[6:0];
            if (op_done)
                op_r <= byte_w;
            if (byte_done && state_r == SNL_ST_ADDR)
                addr_r <= addr_full;
            else if (byte_done && state_r == SNL_ST_DATA)
                addr_r <= addr_inc;
            if (byte_done && state_nxt == SNL_ST_DATA)
                tx_r <= tx_nxt;
        end
    end

    // read data leaves on falling clock edges, msb first
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || pin.cs_high)
        begin
            so_r   <= 1'b0;
            oe_n_r <= 1'b1;
        end
        else if (pin.sck_fall && state_r == SNL_ST_DATA && is_read)
        begin
            so_r   <= tx_r[3'(3'h7 - bit_r)];
            oe_n_r <= 1'b0;
        end
    end

    // command flags: ready, program permission, write seen
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || pin.cs_high)
        begin
            ready_r   <= 1'b0;
            prog_ok_r <= 1'b0;
            wrote_r   <= 1'b0;
        end
        else if (byte_done)
        begin
            ready_r <= (op_done && (byte_w == `SNL_OP_GLOCK ||
                                    byte_w == `SNL_OP_GUNLOCK)) ||
                       (addr_done && (op_r == `SNL_OP_LOCK || op_r == `SNL_OP_UNLOCK));
            if (addr_done && op_r == `SNL_OP_SEC_PROG)
                prog_ok_r <= wel_r & sec_valid(addr_full) & ~sel_otp;
            if (mem_we)
                wrote_r <= 1'b1;
        end
    end

    // otp storage; power-on shows it erased, soft reset leaves it alone
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            for (int k = 0; k < SEC_DEPTH; k++)
                mem_r[k] <= `SNL_ERASED;
        end
        else if (mem_we)
            mem_r[wr_idx] <= byte_w;
    end

    // program completion waits for chip select to rise after the data
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || sw_rst)
        begin
            wel_r    <= 1'b0;
            busy_r   <= 1'b0;
            pcnt_r   <= 16'h0000;
            rst_en_r <= 1'b0;
        end
        else
        begin
            if (op_done && !rst_busy)
                rst_en_r <= (byte_w == `SNL_OP_RST_EN);
            if (pin.cs_rise && wrote_r && !busy_r)
            begin
                busy_r <= 1'b1;
                pcnt_r <= 16'(PROG_CYC);
            end
            else if (busy_r)
            begin
                pcnt_r <= 16'(pcnt_r - 16'h0001);
                if (pcnt_r == 16'h0001)
                begin
                    busy_r <= 1'b0;
                    wel_r  <= 1'b0;
                end
            end
            if (op_done && !rst_busy && !busy_r && byte_w == `SNL_OP_WREN)
                wel_r <= 1'b1;
            else if (apply)
                wel_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            rcnt_r  <= 16'h0000;
            rbusy_r <= 1'b0;
        end
        else
        begin
            // registered copy of the counter's non-zero test, same timing
            rbusy_r <= sw_rst | (rst_busy & (rcnt_r != 16'h0001));
            if (sw_rst)
                rcnt_r <= 16'(TRST_CYC);
            else if (rst_busy)
                rcnt_r <= 16'(rcnt_r - 16'h0001);
        end
    end

    // volatile lock bits, one flop per block or sector
    for (genvar gi = 0; gi < N_LOCKS; gi++)
    begin : g_lock
        always_ff @(posedge i_clk)
        begin
            if (!i_resetn || sw_rst || glob_set)
                lock_r[gi] <= 1'b1;
            else if (glob_clr)
                lock_r[gi] <= 1'b0;
            else if (lock_one && tgt_idx == 9'(gi))
                lock_r[gi] <= 1'b1;
            else if (unlock_one && tgt_idx == 9'(gi))
                lock_r[gi] <= 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            srst_r <= 1'b0;
            prot_r <= 1'b1;
        end
        else
        begin
            srst_r <= sw_rst;
            prot_r <= i_protect_scheme_select ?
                      lock_r[lock_index(i_query_addr)] : i_range_prot;
        end
    end

    assign o_serial_out = so_r;
    assign o_so_oe_n    = oe_n_r;
    assign o_busy       = busy_r;
    assign o_wel        = wel_r;
    assign o_reset_busy = rbusy_r;
    assign o_soft_reset = srst_r;
    assign o_protected  = prot_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    chk_prog_needs_wel: assert property ($rose(busy_r) |-> $past(wel_r))
        else $error("program started without write enable");
    chk_erased_only: assert property (mem_we |-> mem_r[wr_idx] == 8'hFF)
        else $error("write into a non-erased byte");
    chk_otp_guard: assert property (mem_we |-> sec_valid(addr_r) &&
        !i_otp_lock_bits[2'(addr_r[13:12] - 2'h1)])
        else $error("write into locked or invalid register");
    chk_reset_pair: assert property (sw_rst |-> $past(rst_en_r, 1) || rst_en_r)
        else $error("reset without enable");
    chk_reset_state: assert property (sw_rst |=> &lock_r && !wel_r && !busy_r
        && o_soft_reset)
        else $error("soft reset did not restore defaults");
    chk_reset_quiet: assert property (rst_busy |-> !mem_we && !apply)
        else $error("command accepted during reset");
    chk_reset_len: assert property (sw_rst |=> rcnt_r == 16'(TRST_CYC)
        ##1 rcnt_r == 16'(TRST_CYC - 1))
        else $error("reset interval wrong");
    chk_glob_unlock: assert property (glob_clr && !sw_rst |=> lock_r == '0 && !wel_r)
        else $error("global unlock failed");
    chk_read_drive: assert property (pin.sck_fall && state_r == SNL_ST_DATA &&
        is_read && !pin.cs_high |=> !o_so_oe_n)
        else $error("read data not driven");
    chk_prog_done: assert property ($fell(busy_r) && !$past(sw_rst) |-> !wel_r)
        else $error("latch left set after program");

    cov_soft_reset: cover property (sw_rst);
    cov_program: cover property ($rose(busy_r));
    cov_read: cover property (byte_done && state_r == SNL_ST_DATA && is_read);
    cov_unlock: cover property (unlock_one);
endmodule : snl_core

// [testbench/snl_host_model.sv]
`timescale 1ns/1ps
module snl_host_model #(
    parameter real HALF = 24.0           // half of the 48 ns link clock period
)(
    input  wire logic i_clk,             // bench clock, only used to start frames
    input  wire logic i_so_line,         // resolved serial out pin
    output logic      o_cs_n,            // chip select, active low
    output logic      o_sclk,            // link clock, still low outside frames
    output logic      o_din              // serial data towards the device
);
    logic [7:0] rx_q [$];

    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din  = 1'b1;
    end

    // sampled late in the high phase: the device needs a few of its clocks to drive
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            o_din  = tx[i];                  // msb first
            #(HALF);
            o_sclk = 1'b1;
            #(HALF - 1.0);
            rx[i]  = i_so_line;
            #1.0;
            o_sclk = 1'b0;
        end
    endtask : xfer

    // chip select stays low over opcode, address and every data byte
    task automatic frame(input logic [7:0] op, input bit use_a, input logic [23:0] a,
                         input logic [7:0] tx [$], input int n_rx);
        logic [7:0] rx;
        rx_q.delete();
        @(posedge i_clk);
        #1.3;
        o_cs_n = 1'b0;
        xfer(op, rx);
        if (use_a)
            for (int k = 2; k >= 0; k--)
                xfer(a[k*8 +: 8], rx);       // 24-bit address, msb first
        foreach (tx[k])
            xfer(tx[k], rx);
        repeat (n_rx)
        begin
            xfer(8'h00, rx);
            rx_q.push_back(rx);
        end
        #(HALF);
        o_cs_n = 1'b1;
        // released line has no pull: show the inverse so a stale value cannot pass
        o_din  = ~o_din;
        #100.0;
    endtask : frame
endmodule : snl_host_model

// [testbench/snl_core_test.sv]
`timescale 1ns/1ps
`include "snl_map.svh"
module snl_core_test;
    localparam int TRST = 300;
    localparam int PROG = 8;
    localparam int NL   = `SNL_LOCK_COUNT;
    localparam logic [23:0] TBL [3] = '{24'h003000, 24'h5A0000, 24'hFFF000};

    logic        clk, resetn, cs_n, sclk, din, sch, rp;
    logic [2:0]  otp;
    logic [23:0] qa, la;
    logic        so, so_oe_n, busy, write_enable_latch, rbusy, srst, prot;
    wire         so_line = so_oe_n ? 1'bz : so;
    int          n_mismatch = 0, checks_done = 0;
    int          busy_cnt = 0, rb_cnt = 0, sr_cnt = 0, b0, r0, s0;
    bit          lock_m [NL];
    bit          wel_m;
    logic [7:0]  none_q [$], dat [$];
    logic [7:0]  dq1 [$] = '{8'h00};

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        busy_cnt <= busy_cnt + int'(busy === 1'b1);
        rb_cnt   <= rb_cnt + int'(rbusy === 1'b1);
        sr_cnt   <= sr_cnt + int'(srst === 1'b1);
    end

    snl_core #(.TRST_CYC(TRST), .PROG_CYC(PROG), .N_LOCKS(NL)) i_snl_core (
        .i_clk(clk), .i_resetn(resetn), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_serial_in(din), .i_otp_lock_bits(otp), .i_protect_scheme_select(sch),
        .i_range_prot(rp), .i_query_addr(qa), .o_serial_out(so), .o_so_oe_n(so_oe_n),
        .o_busy(busy), .o_wel(write_enable_latch), .o_reset_busy(rbusy), .o_soft_reset(srst),
        .o_protected(prot));

    snl_host_model i_snl_host_model (
        .i_clk(clk), .i_so_line(so_line), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic done(input string name);
        $display("test %s finished: %0d checks, %0d mismatches", name, checks_done, n_mismatch);
    endtask : done

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : ticks

    task automatic wait_for(input bit sel, input logic val, input int lim);
        int k;
        k = 0;
        while ((sel ? rbusy : busy) !== val)
        begin
            @(posedge clk);
            k++;
            if (k > lim)
            begin
                n_mismatch++;
                $display("mismatch at %0t: wait ran out, got %h expected %h", $time, ~val, val);
                close_out();
            end
        end
    endtask : wait_for

    function automatic int lidx(input logic [23:0] a);
        if (a[23:16] == 8'h00)
            return int'(a[15:12]);
        if (a[23:16] == 8'hFF)
            return 270 + int'(a[15:12]);
        return 15 + int'(a[23:16]);
    endfunction : lidx

    task automatic set_all(input bit v);
        foreach (lock_m[k])
            lock_m[k] = v;
        wel_m = 1'b0;
    endtask : set_all

    task automatic op(input logic [7:0] o);
        i_snl_host_model.frame(o, 1'b0, 24'h000000, none_q, 0);
    endtask : op

    task automatic wren;
        op(`SNL_OP_WREN);
        wel_m = 1'b1;
    endtask : wren

    task automatic cmd_a(input logic [7:0] o, input logic [23:0] a);
        i_snl_host_model.frame(o, 1'b1, a, none_q, 0);
    endtask : cmd_a

    task automatic probe(input logic [23:0] a, input bit s);
        logic r;
        r = 1'($urandom);
        @(posedge clk);
        qa  <= a;
        sch <= s;
        rp  <= r;
        ticks(3);
        cmp_bit(prot, s ? lock_m[lidx(a)] : r);
    endtask : probe

    task automatic rand_probe(input int n);
        logic [23:0] a;
        repeat (n)
        begin
            a = 24'($urandom);
            if (a[2])
                a[23:16] = {8{a[3]}};   // reach the sector-granular end blocks too
            probe(a, a[4] | a[5]);
        end
    endtask : rand_probe

    task automatic read_chk(input logic [7:0] o, input logic [23:0] a, input int nd,
                            input int n, input logic [7:0] e);
        logic [7:0] dq [$];
        repeat (nd) dq.push_back(8'h00);
        i_snl_host_model.frame(o, 1'b1, a, dq, n);
        foreach (i_snl_host_model.rx_q[k])
            cmp_byte(i_snl_host_model.rx_q[k], e);
    endtask : read_chk

    initial
    begin
        void'($urandom(32'h5B26));
        resetn = 1'b0;
        otp = 3'h1;
        sch = 1'b1;
        rp = 1'b0;
        qa = 24'h000000;
        set_all(1'b1);
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        ticks(4);
        cmp_bit(write_enable_latch, 1'b0);
        cmp_bit(busy | rbusy, 1'b0);
        rand_probe(8);
        done("power_on");

        wren();
        op(`SNL_OP_GUNLOCK);
        set_all(1'b0);
        cmp_bit(write_enable_latch, wel_m);
        rand_probe(6);
        foreach (TBL[k])
        begin
            la = TBL[k];
            cmd_a(`SNL_OP_LOCK, la);
            probe(la, 1'b1);
            wren();
            cmd_a(`SNL_OP_LOCK, la);
            lock_m[lidx(la)] = 1'b1;
            probe(la, 1'b1);
            probe(la ^ 24'h011000, 1'b1);
            read_chk(`SNL_OP_RD_LOCK, la, 0, 2, 8'h01);
            read_chk(`SNL_OP_RD_LOCK, la ^ 24'h011000, 0, 2, 8'h00);
            wren();
            cmd_a(`SNL_OP_UNLOCK, la);
            lock_m[lidx(la)] = 1'b0;
            wel_m = 1'b0;
            probe(la, 1'b1);
            cmp_bit(write_enable_latch, wel_m);
        end
        wren();
        op(`SNL_OP_GLOCK);
        set_all(1'b1);
        rand_probe(6);
        op(`SNL_OP_GUNLOCK);
        rand_probe(4);
        done("lock_bits");

        read_chk(`SNL_OP_SEC_READ, 24'h004000, 1, 3, 8'hFF);
        read_chk(`SNL_OP_SEC_READ, 24'h001100, 1, 2, 8'hFF);
        read_chk(`SNL_OP_SEC_READ, 24'h011000, 1, 2, 8'hFF);
        repeat (2) dat.push_back(8'($urandom));
        b0 = busy_cnt;
        i_snl_host_model.frame(`SNL_OP_SEC_PROG, 1'b1, 24'h001010, dat, 0);
        cmp_bit(busy_cnt == b0, 1'b1);
        wren();
        i_snl_host_model.frame(`SNL_OP_SEC_PROG, 1'b1, 24'h001010, dat, 0);
        cmp_bit(busy_cnt == b0, 1'b1);
        @(posedge clk);
        otp <= 3'h6;
        wren();
        i_snl_host_model.frame(`SNL_OP_SEC_PROG, 1'b1, 24'h0010FE, dat, 0);
        wait_for(1'b0, 1'b0, 4 * PROG); // host checks busy before going on
        cmp_bit(busy_cnt - b0 >= PROG && busy_cnt - b0 <= PROG + 1, 1'b1);
        wel_m = 1'b0;
        cmp_bit(write_enable_latch, wel_m);
        i_snl_host_model.frame(`SNL_OP_SEC_READ, 1'b1, 24'h0010FE, dq1, 3);
        cmp_byte(i_snl_host_model.rx_q[0], dat[0]);
        cmp_byte(i_snl_host_model.rx_q[1], dat[1]);
        cmp_byte(i_snl_host_model.rx_q[2], `SNL_ERASED);
        done("security");

        wren();
        op(`SNL_OP_GUNLOCK);
        set_all(1'b0);
        op(`SNL_OP_RST_EN);
        wren();
        op(`SNL_OP_RST);
        cmp_bit(rbusy, 1'b0);
        cmp_bit(write_enable_latch, wel_m);
        rand_probe(3);
        r0 = rb_cnt;
        s0 = sr_cnt;
        op(`SNL_OP_RST_EN);
        op(`SNL_OP_RST);
        cmp_bit(rbusy, 1'b1);
        op(`SNL_OP_WREN);
        wait_for(1'b1, 1'b0, TRST + 20);
        cmp_bit(rb_cnt - r0 >= TRST && rb_cnt - r0 <= TRST + 1, 1'b1);
        cmp_bit(sr_cnt - s0 == 1, 1'b1);
        set_all(1'b1);
        cmp_bit(write_enable_latch, wel_m);
        rand_probe(8);
        done("soft_reset");
        close_out();
    end
endmodule : snl_core_test
